// ### core/gpm_pin_mux.sv
// general i/o pin multiplexer: alternate roles, pull-ups, sleep hold, reset pin
// assumes pads resolve level from oe/out/pull; all inputs synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module gpm_pin_mux (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // software settings per line
  input wire gpm_pkg::gpm_lines_t sw_dir_out,
  input wire gpm_pkg::gpm_lines_t sw_out_level,
  input wire gpm_pkg::gpm_lines_t sw_pull_en,
  input wire gpm_pkg::gpm_lines_t sw_irq_en,
  output gpm_pkg::gpm_lines_t gpio_in_level,
  // peripherals
  input wire gpm_pkg::gpm_periph_en_s periph_en,
  input wire gpm_pkg::gpm_periph_out_s periph_out,
  output gpm_pkg::gpm_periph_in_s periph_in,
  // power control
  input wire logic sleep_req,
  output logic sleep_active,
  output logic wake_event,
  // general i/o pads
  input wire gpm_pkg::gpm_lines_t pad_in,
  output gpm_pkg::gpm_lines_t pad_out,
  output gpm_pkg::gpm_lines_t pad_oe,
  output gpm_pkg::gpm_lines_t pad_pull_en,
  // reset pin and system reset
  input wire logic internal_reset_req,
  input wire logic reset_pin_low_in,
  output logic reset_pin_low_out,
  output logic reset_pin_low_oe,
  output logic reset_pin_pull_en,
  output logic ext_reset_req
);
  import gpm_pkg::*;

  gpm_power_e state_reg;
  gpm_power_e state_next;
  logic wake_reg;
  logic rpin_drive_reg;
  logic rpin_out_reg;
  logic rpin_pull_reg;
  logic ext_reset_reg;
  gpm_lines_t alt_sel;
  gpm_lines_t alt_oe;
  gpm_lines_t alt_out;
  gpm_lines_t line_oe;
  gpm_lines_t line_out;
  gpm_lines_t wake_hit;
  gpm_lines_t in_level;
  wire logic hold;
  wire logic any_wake;

  assign alt_sel[LN_SPI_SEL_1] = periph_en.spi_sel[0];
  assign alt_oe[LN_SPI_SEL_1] = 1'b1;
  assign alt_out[LN_SPI_SEL_1] = periph_out.spi_select_out_1;
  assign alt_sel[LN_SPI_SEL_2] = periph_en.spi_sel[1];
  assign alt_oe[LN_SPI_SEL_2] = 1'b1;
  assign alt_out[LN_SPI_SEL_2] = periph_out.spi_select_out_2;

  // spi select wins over the radio switch when both are on
  assign alt_sel[LN_SPI_SEL_3] = periph_en.spi_sel[2] | periph_en.radio_sw;
  assign alt_oe[LN_SPI_SEL_3] = 1'b1;
  assign alt_out[LN_SPI_SEL_3] = periph_en.spi_sel[2] ? periph_out.spi_select_out_3 :
                                 periph_out.radio_receive_switch_ctl;
  assign alt_sel[LN_SPI_SEL_4] = periph_en.spi_sel[3] | periph_en.radio_sw;
  assign alt_oe[LN_SPI_SEL_4] = 1'b1;
  assign alt_out[LN_SPI_SEL_4] = periph_en.spi_sel[3] ? periph_out.spi_select_out_4 :
                                 periph_out.radio_transmit_switch_ctl;

  // first uart, flow control lines apart from data lines
  assign alt_sel[LN_UA_CTS] = periph_en.uart_a_flow;
  assign alt_oe[LN_UA_CTS] = 1'b0;
  assign alt_out[LN_UA_CTS] = 1'b0;
  assign alt_sel[LN_UA_RTS] = periph_en.uart_a_flow;
  assign alt_oe[LN_UA_RTS] = 1'b1;
  assign alt_out[LN_UA_RTS] = periph_out.uart_a_request_to_send;
  assign alt_sel[LN_UA_TX] = periph_en.uart_a;
  assign alt_oe[LN_UA_TX] = 1'b1;
  assign alt_out[LN_UA_TX] = periph_out.uart_a_transmit;
  assign alt_sel[LN_UA_RX] = periph_en.uart_a;
  assign alt_oe[LN_UA_RX] = 1'b0;
  assign alt_out[LN_UA_RX] = 1'b0;

  // timer a; capture and slow clock are both inputs on one line
  assign alt_sel[LN_TA_CLK] = periph_en.timer_a_clk;
  assign alt_oe[LN_TA_CLK] = 1'b0;
  assign alt_out[LN_TA_CLK] = 1'b0;
  assign alt_sel[LN_TA_CAP] = periph_en.timer_a_cap | periph_en.slow_clock;
  assign alt_oe[LN_TA_CAP] = 1'b0;
  assign alt_out[LN_TA_CAP] = 1'b0;
  assign alt_sel[LN_TA_PWM] = periph_en.timer_a_pwm;
  assign alt_oe[LN_TA_PWM] = 1'b1;
  assign alt_out[LN_TA_PWM] = periph_out.timer_a_pwm_out;

  // timer b; antenna diversity output overrides the capture input
  assign alt_sel[LN_TB_CLK] = periph_en.timer_b_clk;
  assign alt_oe[LN_TB_CLK] = 1'b0;
  assign alt_out[LN_TB_CLK] = 1'b0;
  assign alt_sel[LN_TB_CAP] = periph_en.timer_b_cap | periph_en.antenna_div;
  assign alt_oe[LN_TB_CAP] = periph_en.antenna_div;
  assign alt_out[LN_TB_CAP] = periph_en.antenna_div & periph_out.antenna_diversity_out;
  assign alt_sel[LN_TB_PWM] = periph_en.timer_b_pwm;
  assign alt_oe[LN_TB_PWM] = 1'b1;
  assign alt_out[LN_TB_PWM] = periph_out.timer_b_pwm_out;

  // two-wire is open drain: only ever pulls low; it wins over the slave port
  assign alt_sel[LN_TW_CLK] = periph_en.two_wire | periph_en.slave_port;
  assign alt_oe[LN_TW_CLK] = periph_en.two_wire & periph_out.two_wire_clock_low;
  assign alt_out[LN_TW_CLK] = 1'b0;
  assign alt_sel[LN_TW_DATA] = periph_en.two_wire | periph_en.slave_port;
  assign alt_oe[LN_TW_DATA] = periph_en.two_wire ? periph_out.two_wire_data_low : 1'b1;
  assign alt_out[LN_TW_DATA] = ~periph_en.two_wire & periph_out.slave_port_data_out;
  assign alt_sel[LN_SP_DIN] = periph_en.slave_port;
  assign alt_oe[LN_SP_DIN] = 1'b0;
  assign alt_out[LN_SP_DIN] = 1'b0;

  // second uart; slave port interrupt takes line 18 over the rts
  assign alt_sel[LN_UB_CTS] = periph_en.uart_b_flow | periph_en.slave_port;
  assign alt_oe[LN_UB_CTS] = 1'b0;
  assign alt_out[LN_UB_CTS] = 1'b0;
  assign alt_sel[LN_UB_RTS] = periph_en.uart_b_flow | periph_en.slave_port;
  assign alt_oe[LN_UB_RTS] = 1'b1;
  assign alt_out[LN_UB_RTS] = periph_en.slave_port ? periph_out.slave_port_interrupt_out :
                              periph_out.uart_b_request_to_send;
  assign alt_sel[LN_UB_TX] = periph_en.uart_b;
  assign alt_oe[LN_UB_TX] = 1'b1;
  assign alt_out[LN_UB_TX] = periph_out.uart_b_transmit;
  assign alt_sel[LN_UB_RX] = periph_en.uart_b;
  assign alt_oe[LN_UB_RX] = 1'b0;
  assign alt_out[LN_UB_RX] = 1'b0;

  assign line_oe = (alt_sel & alt_oe) | (~alt_sel & sw_dir_out);
  assign line_out = (alt_sel & alt_out) | (~alt_sel & sw_out_level);

  // sleep freezes drive and pull of every cell from the first edge after entry
  assign hold = (state_reg == PWR_SLEEP);
  assign any_wake = |wake_hit;

  // cell reset gives hi-z input
  // one cell per line; software pull and interrupt pass straight in
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    gpm_line_cell u_cell (
      .clock(clock),
      .rst_n(rst_n),
      .hold(hold),
      .dir_out(line_oe[i]),
      .out_level(line_out[i]),
      .pull_en(sw_pull_en[i]),
      .irq_en(sw_irq_en[i]),
      .pad_in(pad_in[i]),
      .pad_oe(pad_oe[i]),
      .pad_out(pad_out[i]),
      .pad_pull(pad_pull_en[i]),
      .in_level(in_level[i]),
      .wake_hit(wake_hit[i])
    );
  end

  // input levels delivered to peripherals come from the cell flops
  // read levels per line
  assign gpio_in_level = in_level;
  assign periph_in.uart_a_clear_to_send = in_level[LN_UA_CTS];
  assign periph_in.uart_a_receive = in_level[LN_UA_RX];
  assign periph_in.timer_a_clock_gate_in = in_level[LN_TA_CLK];
  assign periph_in.timer_a_capture_in = in_level[LN_TA_CAP];
  assign periph_in.slow_clock_pin = in_level[LN_TA_CAP];
  assign periph_in.timer_b_clock_gate_in = in_level[LN_TB_CLK];
  assign periph_in.timer_b_capture_in = in_level[LN_TB_CAP];
  assign periph_in.two_wire_clock = in_level[LN_TW_CLK];
  assign periph_in.two_wire_data = in_level[LN_TW_DATA];
  assign periph_in.slave_port_clock_in = in_level[LN_TW_CLK];
  assign periph_in.slave_port_data_in = in_level[LN_SP_DIN];
  assign periph_in.slave_port_select_in = in_level[LN_UB_CTS];
  assign periph_in.uart_b_clear_to_send = in_level[LN_UB_CTS];
  assign periph_in.uart_b_receive = in_level[LN_UB_RX];

  // power state: wake or a dropped request ends the hold
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PWR_AWAKE: begin
        if (sleep_req) begin
          state_next = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (any_wake || !sleep_req) begin
          state_next = PWR_AWAKE;
        end
      end
      default: begin
        state_next = PWR_AWAKE;
      end
    endcase
  end

  // state and wake pulse
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= PWR_AWAKE;
      wake_reg <= FLAG_RESET;
    end else begin
      state_reg <= state_next;
      wake_reg <= any_wake;
    end
  end

  // reset pin: drive low only, the pull-up stays on so the wire idles high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rpin_drive_reg <= FLAG_RESET;
      rpin_out_reg <= OUT_RESET;
      rpin_pull_reg <= PULL_RESET;
      ext_reset_reg <= FLAG_RESET;
    end else begin
      rpin_drive_reg <= internal_reset_req;
      rpin_out_reg <= OUT_RESET;
      rpin_pull_reg <= PULL_RESET;
      // outside pull-down seen only while not driving ourselves
      ext_reset_reg <= ~reset_pin_low_in & ~rpin_drive_reg;
    end
  end

  assign sleep_active = state_reg[0];
  assign wake_event = wake_reg;
  assign reset_pin_low_oe = rpin_drive_reg;
  assign reset_pin_low_out = rpin_out_reg;
  assign reset_pin_pull_en = rpin_pull_reg;
  assign ext_reset_req = ext_reset_reg;

  // checks, all on the single clock
  default clocking cb @(posedge clock);
  endclocking

  chk_spi_select_one: assert property (
    disable iff (!rst_n) (periph_en.spi_sel[0] && !hold)
      |=> pad_oe[LN_SPI_SEL_1] && pad_out[LN_SPI_SEL_1] == $past(periph_out.spi_select_out_1))
    else $error("spi select 1 not routed to line 0");

  chk_radio_rx_route: assert property (
    disable iff (!rst_n) (periph_en.radio_sw && !periph_en.spi_sel[2] && !hold)
      |=> pad_oe[LN_SPI_SEL_3]
          && pad_out[LN_SPI_SEL_3] == $past(periph_out.radio_receive_switch_ctl))
    else $error("radio receive switch not on line 2");

  chk_uart_a_tx: assert property (
    disable iff (!rst_n) (periph_en.uart_a && !hold)
      |=> pad_oe[LN_UA_TX] && !pad_oe[LN_UA_RX]
          && pad_out[LN_UA_TX] == $past(periph_out.uart_a_transmit))
    else $error("first uart lines misrouted");

  chk_timer_a_pwm: assert property (
    disable iff (!rst_n) (periph_en.timer_a_pwm && !hold)
      |=> pad_oe[LN_TA_PWM] && pad_out[LN_TA_PWM] == $past(periph_out.timer_a_pwm_out))
    else $error("timer a pwm not on line 10");

  chk_antenna_div: assert property (
    disable iff (!rst_n) (periph_en.antenna_div && !hold)
      |=> pad_oe[LN_TB_CAP] && pad_out[LN_TB_CAP] == $past(periph_out.antenna_diversity_out))
    else $error("antenna diversity not on line 12");

  chk_two_wire_clk: assert property (
    disable iff (!rst_n) (periph_en.two_wire && !hold)
      |=> pad_oe[LN_TW_CLK] == $past(periph_out.two_wire_clock_low) && !pad_out[LN_TW_CLK])
    else $error("two-wire clock not open drain");

  chk_slave_irq: assert property (
    disable iff (!rst_n) (periph_en.slave_port && !hold)
      |=> pad_oe[LN_UB_RTS] && pad_out[LN_UB_RTS] == $past(periph_out.slave_port_interrupt_out))
    else $error("slave interrupt not on line 18");

  chk_general_dir: assert property (
    disable iff (!rst_n) (!periph_en.slave_port && !hold)
      |=> pad_oe[LN_SP_DIN] == $past(sw_dir_out[LN_SP_DIN])
          && pad_pull_en[LN_SP_DIN] == $past(sw_pull_en[LN_SP_DIN]))
    else $error("general line ignores software direction");

  chk_fixed_input: assert property (
    disable iff (!rst_n) (periph_en.uart_a && sw_dir_out[LN_UA_RX] && !hold) |=> !pad_oe[LN_UA_RX])
    else $error("software drove a fixed input line");

  chk_reset_pull: assert property (
    !rst_n |=> pad_pull_en == '1)
    else $error("pull-ups not on after reset");

  chk_reset_hiz: assert property (
    !rst_n |=> pad_oe == '0)
    else $error("line driven after reset");

  chk_sleep_hold: assert property (
    disable iff (!rst_n) hold |=> $stable(pad_oe) && $stable(pad_out))
    else $error("line changed during sleep");

  chk_wake_line: assert property (
    disable iff (!rst_n) (hold && sw_irq_en[LN_UA_CTS] && !pad_oe[LN_UA_CTS]
      && pad_in[LN_UA_CTS] != gpio_in_level[LN_UA_CTS]) |=> wake_event && !sleep_active)
    else $error("input event did not wake");

  chk_ext_reset: assert property (
    disable iff (!rst_n) (!reset_pin_low_in && !reset_pin_low_oe) |=> ext_reset_req)
    else $error("outside reset not seen");

  chk_reset_drive: assert property (
    disable iff (!rst_n) internal_reset_req |=> reset_pin_low_oe && !reset_pin_low_out)
    else $error("reset pin not driven low");

  chk_in_level: assert property (
    disable iff (!rst_n) rst_n |=> gpio_in_level == $past(pad_in))
    else $error("read level lags pad");
endmodule
`default_nettype wire

// ### core/gpm_pkg.sv
// shared constants, types and carriers of the general i/o pin multiplexer
// assumes one 25 MHz clock and a synchronous active-low reset everywhere
package gpm_pkg;

  // line count and the vector that carries one bit per line
  localparam int NUM_LINES = 21;
  typedef logic [NUM_LINES-1:0] gpm_lines_t;

  // line positions of the alternate functions
  localparam int LN_SPI_SEL_1 = 0;
  localparam int LN_SPI_SEL_2 = 1;
  localparam int LN_SPI_SEL_3 = 2;
  localparam int LN_SPI_SEL_4 = 3;
  localparam int LN_UA_CTS = 4;
  localparam int LN_UA_RTS = 5;
  localparam int LN_UA_TX = 6;
  localparam int LN_UA_RX = 7;
  localparam int LN_TA_CLK = 8;
  localparam int LN_TA_CAP = 9;
  localparam int LN_TA_PWM = 10;
  localparam int LN_TB_CLK = 11;
  localparam int LN_TB_CAP = 12;
  localparam int LN_TB_PWM = 13;
  localparam int LN_TW_CLK = 14;
  localparam int LN_TW_DATA = 15;
  localparam int LN_SP_DIN = 16;
  localparam int LN_UB_CTS = 17;
  localparam int LN_UB_RTS = 18;
  localparam int LN_UB_TX = 19;
  localparam int LN_UB_RX = 20;

  // values after reset
  localparam logic OE_RESET = 1'b0;
  localparam logic OUT_RESET = 1'b0;
  localparam logic PULL_RESET = 1'b1;
  localparam logic IN_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;

  // power state of the pins
  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b00,
    PWR_SLEEP = 2'b01
  } gpm_power_e;

  // peripheral enables, one per alternate role
  typedef struct packed {
    logic [3:0] spi_sel;
    logic radio_sw;
    logic uart_a_flow;
    logic uart_a;
    logic timer_a_clk;
    logic timer_a_cap;
    logic slow_clock;
    logic timer_a_pwm;
    logic timer_b_clk;
    logic timer_b_cap;
    logic antenna_div;
    logic timer_b_pwm;
    logic two_wire;
    logic slave_port;
    logic uart_b_flow;
    logic uart_b;
  } gpm_periph_en_s;

  // levels that peripherals send toward the pins
  typedef struct packed {
    logic spi_select_out_1;
    logic spi_select_out_2;
    logic spi_select_out_3;
    logic spi_select_out_4;
    logic radio_receive_switch_ctl;
    logic radio_transmit_switch_ctl;
    logic uart_a_request_to_send;
    logic uart_a_transmit;
    logic timer_a_pwm_out;
    logic antenna_diversity_out;
    logic timer_b_pwm_out;
    logic two_wire_clock_low;
    logic two_wire_data_low;
    logic slave_port_data_out;
    logic slave_port_interrupt_out;
    logic uart_b_request_to_send;
    logic uart_b_transmit;
  } gpm_periph_out_s;

  // levels that the pins deliver to peripherals
  typedef struct packed {
    logic uart_a_clear_to_send;
    logic uart_a_receive;
    logic timer_a_clock_gate_in;
    logic timer_a_capture_in;
    logic slow_clock_pin;
    logic timer_b_clock_gate_in;
    logic timer_b_capture_in;
    logic two_wire_clock;
    logic two_wire_data;
    logic slave_port_clock_in;
    logic slave_port_data_in;
    logic slave_port_select_in;
    logic uart_b_clear_to_send;
    logic uart_b_receive;
  } gpm_periph_in_s;

endpackage

// ### core/gpm_line_cell.sv
// one general i/o line: registered drive, pull-up, sampled input, sleep hold
// assumes pad_in is synchronous to clock and hold comes from a flop
`timescale 1ns/1ps
`default_nettype none
module gpm_line_cell (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // selected drive for this line
  input wire logic hold,
  input wire logic dir_out,
  input wire logic out_level,
  input wire logic pull_en,
  input wire logic irq_en,
  // pad side
  input wire logic pad_in,
  output logic pad_oe,
  output logic pad_out,
  output logic pad_pull,
  output logic in_level,
  output logic wake_hit
);
  import gpm_pkg::*;

  logic oe_reg;
  logic out_reg;
  logic pull_reg;
  logic in_reg;

  // reset leaves a high-impedance input with pull-up on
  // while held, drive and pull keep the state from sleep entry
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oe_reg <= OE_RESET;
      out_reg <= OUT_RESET;
      pull_reg <= PULL_RESET;
      in_reg <= IN_RESET;
    end else begin
      in_reg <= pad_in;
      if (!hold) begin
        oe_reg <= dir_out;
        out_reg <= out_level;
        pull_reg <= pull_en;
      end
    end
  end

  // an input line with interrupt enabled flags any level change in sleep
  assign wake_hit = hold & irq_en & ~oe_reg & (pad_in ^ in_reg);

  assign pad_oe = oe_reg;
  assign pad_out = out_reg;
  assign pad_pull = pull_reg;
  assign in_level = in_reg;
endmodule
`default_nettype wire

// ### verif/gpm_pad_model.sv
// devices wired to the general i/o pads and the reset wire
// assumes the bench commands every external drive; pull-ups resolve idle lines
`timescale 1ns/1ps
`default_nettype none
module gpm_pad_model (
  // clock
  input wire logic clock,
  // pad side of the mux
  input wire gpm_pkg::gpm_lines_t pad_out,
  input wire gpm_pkg::gpm_lines_t pad_oe,
  input wire gpm_pkg::gpm_lines_t pad_pull_en,
  output gpm_pkg::gpm_lines_t pad_in,
  // external drive commanded by the bench
  input wire gpm_pkg::gpm_lines_t ext_en,
  input wire gpm_pkg::gpm_lines_t ext_level,
  // reset wire
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic rst_pin_pull,
  input wire logic ext_rst_drive,
  output logic reset_wire
);
  import gpm_pkg::*;
  gpm_lines_t last_reg = '0;
  logic last_rst_reg = 1'b0;
  // line level; two drivers at once give unknown, a floating line flips every cycle
  // pull-up idle
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      if (pad_oe[i] && ext_en[i]) begin
        pad_in[i] = 1'bx;
      end else if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_level[i];
      end else if (pad_pull_en[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last_reg[i];
      end
    end
  end
  // reset wire: outside circuit may pull low, device may drive low, else pull-up
  // wired reset
  always_comb begin
    if (ext_rst_drive || rst_pin_oe) begin
      reset_wire = (ext_rst_drive) ? 1'b0 : rst_pin_out;
    end else begin
      reset_wire = (rst_pin_pull) ? 1'b1 : ~last_rst_reg;
    end
  end
  // memory of last levels for the floating pattern
  always_ff @(posedge clock) begin
    last_reg <= pad_in;
    last_rst_reg <= reset_wire;
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench of the pin multiplexer with the pad model
// assumes inputs change at the falling edge and outputs answer one edge later
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpm_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  gpm_lines_t sw_dir_out, sw_out_level, sw_pull_en, sw_irq_en, gpio_in_level;
  gpm_lines_t pad_in, pad_out, pad_oe, pad_pull_en, ext_en, ext_level;
  gpm_periph_en_s periph_en;
  gpm_periph_out_s periph_out;
  gpm_periph_in_s periph_in;
  logic sleep_req, sleep_active, wake_event, internal_reset_req, reset_wire;
  logic rst_pin_out, rst_pin_oe, rst_pin_pull, ext_reset_req, ext_rst_drive;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;

  // 25 MHz clock
  always #20 clock = ~clock;

  gpm_pin_mux gpm_pin_mux_inst (.clock(clock), .rst_n(rst_n), .sw_dir_out(sw_dir_out),
    .sw_out_level(sw_out_level), .sw_pull_en(sw_pull_en), .sw_irq_en(sw_irq_en),
    .gpio_in_level(gpio_in_level), .periph_en(periph_en), .periph_out(periph_out),
    .periph_in(periph_in), .sleep_req(sleep_req), .sleep_active(sleep_active),
    .wake_event(wake_event), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .internal_reset_req(internal_reset_req),
    .reset_pin_low_in(reset_wire), .reset_pin_low_out(rst_pin_out),
    .reset_pin_low_oe(rst_pin_oe), .reset_pin_pull_en(rst_pin_pull),
    .ext_reset_req(ext_reset_req));

  gpm_pad_model gpm_pad_model_inst (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .pad_in(pad_in), .ext_en(ext_en), .ext_level(ext_level),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .rst_pin_pull(rst_pin_pull),
    .ext_rst_drive(ext_rst_drive), .reset_wire(reset_wire));

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs about fifty cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      error_cnt++;
      $display("BAD timeout expected end seen hang");
      conclude();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk(input string name, input gpm_lines_t exp, input gpm_lines_t got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one peripheral enabled over an all-output general setting; im = input lines
  task automatic chk_route(input logic [18:0] en, input gpm_lines_t im, input gpm_lines_t om);
    periph_en = gpm_periph_en_s'(en);
    step(1);
    chk("pad_oe", ~im, pad_oe);
    chk("pad_out", om, pad_out);
    chk("pad_pull_en", sw_pull_en, pad_pull_en);
  endtask

  initial begin
    sw_dir_out = '1;
    sw_out_level = '1;
    sw_pull_en = '0;
    sw_irq_en = '0;
    periph_en = '0;
    periph_out = '1;
    periph_out.two_wire_clock_low = 1'b0;
    periph_out.two_wire_data_low = 1'b0;
    sleep_req = 1'b0;
    internal_reset_req = 1'b0;
    ext_en = '0;
    ext_level = '0;
    ext_rst_drive = 1'b0;
    step(8);
    chk("pad_oe", '0, pad_oe);
    chk("pad_pull_en", '1, pad_pull_en);
    chk("reset_pin_pull_en", 21'h1, {20'h0, rst_pin_pull});
    rst_n = 1'b1;
    // general role: software drives level, pulls dropped per line
    sw_out_level = 21'h15a5a5;
    sw_pull_en = 21'h0a5a5a;
    step(1);
    chk("pad_oe", '1, pad_oe);
    chk("pad_out", 21'h15a5a5, pad_out);
    chk("pad_pull_en", 21'h0a5a5a, pad_pull_en);
    sw_out_level = '0;
    chk_route(19'h78000, 21'h0, 21'h00000f); // spi selects
    chk_route(19'h04000, 21'h0, 21'h00000c); // radio switch
    chk_route(19'h02000, 21'h000010, 21'h000020); // flow control a
    chk_route(19'h01000, 21'h000080, 21'h000040); // uart a data
    chk_route(19'h00800, 21'h000100, 21'h0); // clock gate a
    chk_route(19'h00400, 21'h000200, 21'h0); // capture a
    chk_route(19'h00200, 21'h000200, 21'h0); // slow clock
    chk_route(19'h00100, 21'h0, 21'h000400); // pwm a
    chk_route(19'h00080, 21'h000800, 21'h0); // clock gate b
    chk_route(19'h00040, 21'h001000, 21'h0); // capture b
    chk_route(19'h00020, 21'h0, 21'h001000); // antenna output
    chk_route(19'h00010, 21'h0, 21'h002000); // pwm b
    chk_route(19'h00008, 21'h00c000, 21'h0); // two-wire released
    chk_route(19'h00004, 21'h034000, 21'h048000); // slave port
    chk_route(19'h00002, 21'h020000, 21'h040000); // flow control b
    chk_route(19'h00001, 21'h100000, 21'h080000); // uart b
    sw_dir_out = '0;
    chk_route(19'h00001, 21'h17ffff, 21'h080000); // direction fixed
    // inputs read back, also toward peripherals
    // release the lines a cycle before the outside drive, so no line sees two drivers
    periph_en = '0;
    step(1);
    ext_en = '1;
    ext_level = 21'h0aaaaa;
    step(1);
    chk("gpio_in_level", 21'h0aaaaa, gpio_in_level);
    chk("periph_in", 21'h001726, {7'h0, periph_in});
    chk("uart_a_receive", 21'h1, {20'h0, periph_in.uart_a_receive});
    chk("uart_b_receive", 21'h0, {20'h0, periph_in.uart_b_receive});
    ext_level = 21'h155555;
    step(1);
    chk("gpio_in_level", 21'h155555, gpio_in_level);
    chk("periph_in", 21'h0028d9, {7'h0, periph_in});
    ext_en = '0;
    sw_pull_en = '1;
    step(2);
    chk("gpio_in_level", '1, gpio_in_level);
    // sleep hold, then wake from an input line
    ext_en = 21'h000110;
    ext_level = 21'h000110;
    sw_irq_en = 21'h000010;
    sw_dir_out = 21'h1ffeef;
    sw_out_level = 21'h0f0f0f;
    step(2);
    sleep_req = 1'b1;
    step(1);
    chk("sleep_active", 21'h1, {20'h0, sleep_active});
    sw_out_level = 21'h10f0f0;
    sw_dir_out = '0;
    step(2);
    chk("pad_out", 21'h0f0f0f, pad_out);
    chk("pad_oe", 21'h1ffeef, pad_oe);
    ext_level = 21'h000010;
    step(1);
    chk("wake_event", 21'h0, {20'h0, wake_event});
    chk("sleep_active", 21'h1, {20'h0, sleep_active});
    ext_level = 21'h0;
    step(1);
    chk("wake_event", 21'h1, {20'h0, wake_event});
    sleep_req = 1'b0;
    step(2);
    chk("wake_event", 21'h0, {20'h0, wake_event});
    chk("sleep_active", 21'h0, {20'h0, sleep_active});
    chk("pad_oe", 21'h0, pad_oe);
    // reset wire: own drive, then outside pull-down
    internal_reset_req = 1'b1;
    step(1);
    chk("reset_pin_low_oe", 21'h1, {20'h0, rst_pin_oe});
    chk("reset_pin_low_out", 21'h0, {20'h0, rst_pin_out});
    step(1);
    chk("ext_reset_req", 21'h0, {20'h0, ext_reset_req});
    internal_reset_req = 1'b0;
    step(2);
    chk("reset_pin_low_oe", 21'h0, {20'h0, rst_pin_oe});
    chk("ext_reset_req", 21'h0, {20'h0, ext_reset_req});
    ext_rst_drive = 1'b1;
    step(2);
    chk("ext_reset_req", 21'h1, {20'h0, ext_reset_req});
    ext_rst_drive = 1'b0;
    step(2);
    chk("ext_reset_req", 21'h0, {20'h0, ext_reset_req});
    // reset in mid-run releases every line
    ext_en = '0;
    sw_dir_out = '1;
    sw_pull_en = '0;
    step(1);
    rst_n = 1'b0;
    step(1);
    chk("pad_oe", '0, pad_oe);
    chk("pad_pull_en", '1, pad_pull_en);
    rst_n = 1'b1;
    step(1);
    chk("pad_oe", '1, pad_oe);
    chk("pad_pull_en", '0, pad_pull_en);
    conclude();
  end
endmodule
`default_nettype wire
